// File: rtl/axb_pkg.sv
`default_nettype none
// How it works
// R1: four masters reach ten ports, up to four transfers at once
// R2: address, write and read data paths are 32 bits
// R3: masters are core0, core1, dma read, dma write
// R4: ports: rom, flash exec, six sram, fast periph, apb
// R5: no fabric wait state; only contention or slave waits stall
// R6: splitter decodes upper address bits, forwards to one port
// R7: master gets responses only from the port serving it
// R8: arbiter steers responses to the data phase owner
// R9: four splitters, ten arbiters, forty point-to-point channels
// R10: new address phase overlaps another port's data phase, no cycle lost
// R11: two priority levels, one software bit per master
// R12: priority 1 granted before priority 0
// R13: ties at the highest level granted round-robin
// R14: arbitration only among masters hitting one port in one cycle
// R15: high priority never waits for low priority at zero-wait slaves
// R16: four 24-bit saturating up counters
// R17: counter read returns value; any write clears (a write in the cycle of a counted event loads 1 instead of 0)
// R18: each counter counts one of twenty completion events by its select
// R19: contested events count only previously delayed accesses
// R20: codes 0,1 apb contested/all; 2,3 fast periph
// R21: codes 4 to 15 pair sram five down to zero, even contested
// R22: codes 16,17 flash exec contested/all; 18,19 rom
// R23: priority bits 12 dma write, 8 dma read, 4 core1, 0 core0, reset low
// R24: round-robin pointer of a level moves to each granted master
package axb_pkg;
    localparam int NUM_MST = 4;
    localparam int NUM_SLV = 10;
    localparam int AHB_AW = 32;
    localparam int AHB_DW = 32;
    localparam int PORT_W = 4;
    localparam int MST_W = 2;
    localparam int MST_CORE0 = 0;
    localparam int MST_CORE1 = 1;
    localparam int MST_DMA_RD = 2;
    localparam int MST_DMA_WR = 3;
    localparam logic [PORT_W-1:0] PORT_ROM = 4'h0;
    localparam logic [PORT_W-1:0] PORT_FLASH = 4'h1;
    localparam logic [PORT_W-1:0] PORT_SRAM0 = 4'h2;
    localparam logic [PORT_W-1:0] PORT_FAST = 4'h8;
    localparam logic [PORT_W-1:0] PORT_APB = 4'h9;
    localparam int NUM_SRAM = 6;
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic HRESP_OKAY = 1'b0;
    localparam logic HRESP_ERROR = 1'b1;
    localparam int REGION_LSB = 28;
    localparam logic [3:0] REGION_ROM = 4'h0;
    localparam logic [3:0] REGION_FLASH = 4'h1;
    localparam logic [3:0] REGION_SRAM = 4'h2;
    localparam logic [3:0] REGION_APB = 4'h4;
    localparam logic [3:0] REGION_FAST = 4'h5;
    localparam int SRAM_BANK_LSB = 15;
    localparam int REG_AW = 8;
    localparam logic [REG_AW-1:0] OFF_PRIO = 8'h00;
    localparam logic [REG_AW-1:0] OFF_PRIO_ACK = 8'h04;
    localparam logic [REG_AW-1:0] OFF_PERF_BASE = 8'h08;
    localparam logic [REG_AW-1:0] OFF_PERF_STRIDE = 8'h08;
    localparam logic [REG_AW-1:0] OFF_PERF_SEL = 8'h04;
    localparam int PRIO_BIT_STRIDE = 4;
    localparam int PRIO_REG_W = 13;
    localparam logic [PRIO_REG_W-1:0] PRIO_RESET = 13'h0000;
    localparam logic [PRIO_REG_W-1:0] PRIO_MASK = 13'h1111;
    localparam logic [AHB_DW-1:0] PRIO_ACK_VAL = 32'h0000_0001;
    localparam int NUM_PERF = 4;
    localparam int PERF_W = 24;
    localparam int SEL_W = 5;
    localparam int NUM_EVENTS = 20;
    localparam logic [SEL_W-1:0] SEL_RESET = 5'h1f;
    localparam logic [PORT_W-1:0] EVENT_PORT_TOP = 4'h9;

    typedef enum logic [1:0] {ERR_NONE, ERR_FIRST, ERR_SECOND} axb_err_t;

    // returns {mapped, port}
    function automatic logic [PORT_W:0] axb_decode(input logic [AHB_AW-1:0] addr);
        logic [2:0] bank;
        bank = addr[SRAM_BANK_LSB+2:SRAM_BANK_LSB];
        case (addr[AHB_AW-1:REGION_LSB])
            REGION_ROM: axb_decode = {1'b1, PORT_ROM}; // R4
            REGION_FLASH: axb_decode = {1'b1, PORT_FLASH};
            REGION_SRAM: axb_decode = (bank < 3'(NUM_SRAM)) ? {1'b1, PORT_SRAM0 + {1'b0, bank}} : '0;
            REGION_APB: axb_decode = {1'b1, PORT_APB};
            REGION_FAST: axb_decode = {1'b1, PORT_FAST};
            default: axb_decode = '0;
        endcase
    endfunction

    // events pair from apb down to rom
    function automatic logic [PORT_W-1:0] axb_event_port(input logic [SEL_W-1:0] sel);
        axb_event_port = EVENT_PORT_TOP - sel[SEL_W-1:1];
    endfunction
endpackage
`default_nettype wire

// File: rtl/axb_arb.sv
`timescale 1ns/1ps
`default_nettype none
module axb_arb
    import axb_pkg::*;
#(
    parameter int N = NUM_MST
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [N-1:0] req_i,
    input wire logic [N-1:0] prio_i,
    input wire logic ready_i,
    output logic [N-1:0] gnt_o
);
    localparam int IW = (N > 1) ? $clog2(N) : 1;

    if (N < 2) begin : g_chk
        $error("need two requesters");
    end

    logic [IW-1:0] last_hi_q;
    logic [IW-1:0] last_lo_q;
    logic hi_any;
    logic [N-1:0] cand;
    logic [IW-1:0] win;
    logic found;

    always_comb begin
        int idx;
        idx = 0;
        hi_any = |(req_i & prio_i);
        cand = hi_any ? (req_i & prio_i) : req_i; // R12
        win = '0;
        found = 1'b0;
        for (int i = 1; i <= N; i++) begin
            idx = (int'(hi_any ? last_hi_q : last_lo_q) + i) % N; // R13
            if (!found && cand[idx]) begin
                found = 1'b1;
                win = IW'(idx);
            end
        end
        gnt_o = '0;
        if (ready_i && found) begin
            gnt_o[win] = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last_hi_q <= IW'(N - 1);
            last_lo_q <= IW'(N - 1);
        end else if (ready_i && found) begin
            if (hi_any) begin
                last_hi_q <= win; // R24
            end else begin
                last_lo_q <= win; // R24
            end
        end
    end
endmodule
`default_nettype wire

// File: rtl/axb_perf.sv
`timescale 1ns/1ps
`default_nettype none
module axb_perf
    import axb_pkg::*;
#(
    parameter int W = PERF_W
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic event_i,
    input wire logic clear_i,
    output logic [W-1:0] count_o
);
    if (W < 1) begin : g_chk
        $error("bad width");
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_o <= '0;
        end else if (clear_i) begin
            count_o <= event_i ? W'(1) : '0; // R17
        end else if (event_i && count_o != '1) begin
            count_o <= count_o + W'(1); // R16
        end
    end
endmodule
`default_nettype wire

// File: rtl/axb_crossbar.sv
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module axb_crossbar
    import axb_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [NUM_MST-1:0][AHB_AW-1:0] m_haddr_i,
    input wire logic [NUM_MST-1:0][1:0] m_htrans_i,
    input wire logic [NUM_MST-1:0] m_hwrite_i,
    input wire logic [NUM_MST-1:0][2:0] m_hsize_i,
    input wire logic [NUM_MST-1:0][2:0] m_hburst_i,
    input wire logic [NUM_MST-1:0][3:0] m_hprot_i,
    input wire logic [NUM_MST-1:0][AHB_DW-1:0] m_hwdata_i,
    output logic [NUM_MST-1:0][AHB_DW-1:0] m_hrdata_o,
    output logic [NUM_MST-1:0] m_hready_o,
    output logic [NUM_MST-1:0] m_hresp_o,
    output logic [NUM_SLV-1:0] s_hsel_o,
    output logic [NUM_SLV-1:0][AHB_AW-1:0] s_haddr_o,
    output logic [NUM_SLV-1:0][1:0] s_htrans_o,
    output logic [NUM_SLV-1:0] s_hwrite_o,
    output logic [NUM_SLV-1:0][2:0] s_hsize_o,
    output logic [NUM_SLV-1:0][2:0] s_hburst_o,
    output logic [NUM_SLV-1:0][3:0] s_hprot_o,
    output logic [NUM_SLV-1:0][MST_W-1:0] s_hmaster_o,
    output logic [NUM_SLV-1:0][AHB_DW-1:0] s_hwdata_o,
    output logic [NUM_SLV-1:0] s_hready_o,
    input wire logic [NUM_SLV-1:0][AHB_DW-1:0] s_hrdata_i,
    input wire logic [NUM_SLV-1:0] s_hreadyout_i,
    input wire logic [NUM_SLV-1:0] s_hresp_i,
    input wire logic [REG_AW-1:0] reg_addr_i,
    input wire logic [AHB_DW-1:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [AHB_DW-1:0] reg_rdata_o
);
    if (NUM_EVENTS != 2 * NUM_SLV || NUM_MST != 4 || NUM_SLV != 10) begin : g_chk
        $error("unsupported port counts");
    end

    // per master state
    logic [NUM_MST-1:0] pend_q;
    logic [NUM_MST-1:0][AHB_AW-1:0] hold_addr_q;
    logic [NUM_MST-1:0][1:0] hold_trans_q;
    logic [NUM_MST-1:0] hold_write_q;
    logic [NUM_MST-1:0][2:0] hold_size_q;
    logic [NUM_MST-1:0][2:0] hold_burst_q;
    logic [NUM_MST-1:0][3:0] hold_prot_q;
    logic [NUM_MST-1:0][PORT_W-1:0] hold_port_q;
    logic [NUM_MST-1:0] mdp_valid_q;
    logic [NUM_MST-1:0][PORT_W-1:0] mdp_port_q;
    axb_err_t err_q [NUM_MST];

    // per port state
    logic [NUM_SLV-1:0] pdp_valid_q;
    logic [NUM_SLV-1:0][MST_W-1:0] pdp_own_q;
    logic [NUM_SLV-1:0] pdp_cont_q;

    // software registers
    logic [PRIO_REG_W-1:0] prio_q;
    logic [NUM_PERF-1:0][SEL_W-1:0] sel_q;
    logic [NUM_PERF-1:0][PERF_W-1:0] perf_cnt;
    logic [NUM_PERF-1:0] perf_clr;
    logic [NUM_PERF-1:0] perf_ev;
    logic [AHB_DW-1:0] rd_val;

    // combinational fabric
    logic [NUM_MST-1:0] rdy_c;
    logic [NUM_MST-1:0] live_take;
    logic [NUM_MST-1:0] live_map;
    logic [NUM_MST-1:0][PORT_W-1:0] live_port;
    logic [NUM_MST-1:0] cur_valid;
    logic [NUM_MST-1:0][AHB_AW-1:0] cur_addr;
    logic [NUM_MST-1:0][1:0] cur_trans;
    logic [NUM_MST-1:0] cur_write;
    logic [NUM_MST-1:0][2:0] cur_size;
    logic [NUM_MST-1:0][2:0] cur_burst;
    logic [NUM_MST-1:0][3:0] cur_prot;
    logic [NUM_MST-1:0][PORT_W-1:0] cur_port;
    logic [NUM_MST-1:0] prio_vec;
    logic [NUM_SLV-1:0][NUM_MST-1:0] req;
    logic [NUM_SLV-1:0][NUM_MST-1:0] gnt;
    logic [NUM_SLV-1:0][MST_W-1:0] gnt_idx;
    logic [NUM_MST-1:0] m_gnt;
    logic [NUM_MST-1:0][PORT_W-1:0] m_gnt_port;
    logic [NUM_SLV-1:0] p_done;

    always_comb begin
        logic [PORT_W:0] dec;
        dec = '0;
        for (int m = 0; m < NUM_MST; m++) begin
            prio_vec[m] = prio_q[m * PRIO_BIT_STRIDE]; // R3 R11 R23
            case (err_q[m])
                ERR_FIRST: begin
                    rdy_c[m] = 1'b0;
                end
                ERR_SECOND: begin
                    rdy_c[m] = 1'b1;
                end
                default: begin
                    rdy_c[m] = pend_q[m] ? 1'b0 : (mdp_valid_q[m] ? s_hreadyout_i[mdp_port_q[m]] : 1'b1); // R5
                end
            endcase
            dec = axb_decode(m_haddr_i[m]); // R6
            live_map[m] = dec[PORT_W];
            live_port[m] = dec[PORT_W-1:0];
            live_take[m] = rdy_c[m] && m_htrans_i[m][1];
            cur_valid[m] = pend_q[m] || (live_take[m] && live_map[m]);
            cur_addr[m] = pend_q[m] ? hold_addr_q[m] : m_haddr_i[m];
            cur_trans[m] = pend_q[m] ? hold_trans_q[m] : m_htrans_i[m];
            cur_write[m] = pend_q[m] ? hold_write_q[m] : m_hwrite_i[m];
            cur_size[m] = pend_q[m] ? hold_size_q[m] : m_hsize_i[m];
            cur_burst[m] = pend_q[m] ? hold_burst_q[m] : m_hburst_i[m];
            cur_prot[m] = pend_q[m] ? hold_prot_q[m] : m_hprot_i[m];
            cur_port[m] = pend_q[m] ? hold_port_q[m] : live_port[m];
        end
    end

    always_comb begin
        for (int p = 0; p < NUM_SLV; p++) begin
            for (int m = 0; m < NUM_MST; m++) begin
                req[p][m] = cur_valid[m] && (cur_port[m] == PORT_W'(p)); // R14
            end
        end
    end

    for (genvar p = 0; p < NUM_SLV; p++) begin : g_arb
        axb_arb #(
            .N(NUM_MST)
        ) u_arb (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .req_i(req[p]),
            .prio_i(prio_vec),
            .ready_i(s_hreadyout_i[p]),
            .gnt_o(gnt[p])
        ); // R9 R15
    end

    always_comb begin
        m_gnt = '0;
        m_gnt_port = '0;
        for (int p = 0; p < NUM_SLV; p++) begin
            gnt_idx[p] = '0;
            s_hsel_o[p] = 1'b0;
            s_haddr_o[p] = '0;
            s_htrans_o[p] = HTRANS_IDLE;
            s_hwrite_o[p] = 1'b0;
            s_hsize_o[p] = '0;
            s_hburst_o[p] = '0;
            s_hprot_o[p] = '0;
            for (int m = 0; m < NUM_MST; m++) begin
                if (gnt[p][m]) begin
                    gnt_idx[p] = MST_W'(m);
                    s_hsel_o[p] = 1'b1;
                    s_haddr_o[p] = cur_addr[m]; // R2 R6
                    s_htrans_o[p] = cur_trans[m];
                    s_hwrite_o[p] = cur_write[m];
                    s_hsize_o[p] = cur_size[m];
                    s_hburst_o[p] = cur_burst[m];
                    s_hprot_o[p] = cur_prot[m];
                    m_gnt[m] = 1'b1; // R1
                    m_gnt_port[m] = PORT_W'(p);
                end
            end
            s_hmaster_o[p] = gnt_idx[p];
            s_hwdata_o[p] = m_hwdata_i[pdp_own_q[p]]; // R2 R8
            s_hready_o[p] = s_hreadyout_i[p];
            p_done[p] = pdp_valid_q[p] && s_hreadyout_i[p];
        end
    end

    always_comb begin
        for (int m = 0; m < NUM_MST; m++) begin
            m_hready_o[m] = rdy_c[m];
            m_hrdata_o[m] = s_hrdata_i[mdp_port_q[m]]; // R7
            case (err_q[m])
                ERR_FIRST: begin
                    m_hresp_o[m] = HRESP_ERROR;
                end
                ERR_SECOND: begin
                    m_hresp_o[m] = HRESP_ERROR;
                end
                default: begin
                    m_hresp_o[m] = (mdp_valid_q[m] && !pend_q[m]) ? s_hresp_i[mdp_port_q[m]] : HRESP_OKAY; // R7
                end
            endcase
        end
    end

    // denied address phases are parked
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_q <= '0;
            hold_addr_q <= '0;
            hold_trans_q <= '0;
            hold_write_q <= '0;
            hold_size_q <= '0;
            hold_burst_q <= '0;
            hold_prot_q <= '0;
            hold_port_q <= '0;
        end else begin
            for (int m = 0; m < NUM_MST; m++) begin
                if (m_gnt[m]) begin
                    pend_q[m] <= 1'b0;
                end else if (cur_valid[m] && !pend_q[m]) begin
                    pend_q[m] <= 1'b1;
                    hold_addr_q[m] <= m_haddr_i[m];
                    hold_trans_q[m] <= m_htrans_i[m];
                    hold_write_q[m] <= m_hwrite_i[m];
                    hold_size_q[m] <= m_hsize_i[m];
                    hold_burst_q[m] <= m_hburst_i[m];
                    hold_prot_q[m] <= m_hprot_i[m];
                    hold_port_q[m] <= live_port[m];
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mdp_valid_q <= '0;
            mdp_port_q <= '0;
        end else begin
            for (int m = 0; m < NUM_MST; m++) begin
                if (m_gnt[m]) begin
                    mdp_valid_q[m] <= 1'b1; // R10
                    mdp_port_q[m] <= m_gnt_port[m];
                end else if (rdy_c[m]) begin
                    mdp_valid_q[m] <= 1'b0;
                end
            end
        end
    end

    // unmapped addresses get a two-cycle error
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int m = 0; m < NUM_MST; m++) begin
                err_q[m] <= ERR_NONE;
            end
        end else begin
            for (int m = 0; m < NUM_MST; m++) begin
                case (err_q[m])
                    ERR_FIRST: begin
                        err_q[m] <= ERR_SECOND;
                    end
                    ERR_SECOND: begin
                        err_q[m] <= (live_take[m] && !live_map[m]) ? ERR_FIRST : ERR_NONE;
                    end
                    ERR_NONE: begin
                        if (live_take[m] && !live_map[m]) begin
                            err_q[m] <= ERR_FIRST;
                        end
                    end
                    default: begin
                        err_q[m] <= ERR_NONE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pdp_valid_q <= '0;
            pdp_own_q <= '0;
            pdp_cont_q <= '0;
        end else begin
            for (int p = 0; p < NUM_SLV; p++) begin
                if (s_hreadyout_i[p]) begin
                    pdp_valid_q[p] <= |gnt[p];
                    pdp_own_q[p] <= gnt_idx[p]; // R8
                    pdp_cont_q[p] <= pend_q[gnt_idx[p]] && |gnt[p]; // R19
                end
            end
        end
    end

    always_comb begin
        logic [PORT_W-1:0] ep;
        ep = '0;
        for (int k = 0; k < NUM_PERF; k++) begin
            ep = axb_event_port(sel_q[k]); // R20 R21 R22
            perf_ev[k] = (sel_q[k] < SEL_W'(NUM_EVENTS)) && p_done[ep] && (sel_q[k][0] || pdp_cont_q[ep]); // R18 R19
            perf_clr[k] = reg_we_i && (reg_addr_i == REG_AW'(OFF_PERF_BASE + OFF_PERF_STRIDE * REG_AW'(k))); // R17
        end
    end

    for (genvar k = 0; k < NUM_PERF; k++) begin : g_perf
        axb_perf #(
            .W(PERF_W)
        ) u_perf (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .event_i(perf_ev[k]),
            .clear_i(perf_clr[k]),
            .count_o(perf_cnt[k])
        ); // R16
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prio_q <= PRIO_RESET; // R23
        end else if (reg_we_i && reg_addr_i == OFF_PRIO) begin
            prio_q <= reg_wdata_i[PRIO_REG_W-1:0] & PRIO_MASK; // R11
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int k = 0; k < NUM_PERF; k++) begin
                sel_q[k] <= SEL_RESET;
            end
        end else begin
            for (int k = 0; k < NUM_PERF; k++) begin
                if (reg_we_i && reg_addr_i == REG_AW'(OFF_PERF_BASE + OFF_PERF_STRIDE * REG_AW'(k) + OFF_PERF_SEL)) begin
                    sel_q[k] <= reg_wdata_i[SEL_W-1:0]; // R18
                end
            end
        end
    end

    always_comb begin
        rd_val = '0;
        if (reg_addr_i == OFF_PRIO) begin
            rd_val = {{(AHB_DW - PRIO_REG_W){1'b0}}, prio_q};
        end else if (reg_addr_i == OFF_PRIO_ACK) begin
            rd_val = PRIO_ACK_VAL;
        end
        for (int k = 0; k < NUM_PERF; k++) begin
            if (reg_addr_i == REG_AW'(OFF_PERF_BASE + OFF_PERF_STRIDE * REG_AW'(k))) begin
                rd_val = {{(AHB_DW - PERF_W){1'b0}}, perf_cnt[k]}; // R17
            end
            if (reg_addr_i == REG_AW'(OFF_PERF_BASE + OFF_PERF_STRIDE * REG_AW'(k) + OFF_PERF_SEL)) begin
                rd_val = {{(AHB_DW - SEL_W){1'b0}}, sel_q[k]};
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= '0;
        end else begin
            reg_rdata_o <= reg_re_i ? rd_val : '0;
        end
    end
endmodule
`default_nettype wire

// File: tb/axb_crossbar_properties.sv
`timescale 1ns/1ps
`default_nettype none
module axb_crossbar_properties
    import axb_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [NUM_MST-1:0][AHB_AW-1:0] m_haddr_i,
    input wire logic [NUM_MST-1:0][1:0] m_htrans_i,
    input wire logic [NUM_MST-1:0][AHB_DW-1:0] m_hrdata_o,
    input wire logic [NUM_MST-1:0] m_hready_o,
    input wire logic [NUM_MST-1:0] m_hresp_o,
    input wire logic [NUM_SLV-1:0] s_hsel_o,
    input wire logic [NUM_SLV-1:0][AHB_AW-1:0] s_haddr_o,
    input wire logic [NUM_SLV-1:0][1:0] s_htrans_o,
    input wire logic [NUM_SLV-1:0][MST_W-1:0] s_hmaster_o,
    input wire logic [NUM_SLV-1:0] s_hready_o,
    input wire logic [NUM_SLV-1:0][AHB_DW-1:0] s_hrdata_i,
    input wire logic [NUM_SLV-1:0] s_hreadyout_i,
    input wire logic [REG_AW-1:0] reg_addr_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    input wire logic [AHB_DW-1:0] reg_rdata_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic g0;
    // sram0 port granted to core0
    assign g0 = s_hsel_o[2] && s_htrans_o[2][1] && s_hmaster_o[2] == 2'h0;
    AST_HREADY_PASS: assert property (s_hready_o == s_hreadyout_i)
        else $error("ready");
    AST_ROUTE: assert property (g0 && m_htrans_i[0][1] && m_hready_o[0] |-> s_haddr_o[2] == m_haddr_i[0])
        else $error("route");
    AST_STEER: assert property (g0 && s_hready_o[2] |=> m_hrdata_o[0] == s_hrdata_i[2])
        else $error("steer");
    AST_ZERO_WAIT: assert property (g0 && s_hready_o[2] ##1 s_hreadyout_i[2] |-> m_hready_o[0])
        else $error("wait");
    AST_ERR_TWO: assert property (m_htrans_i[0][1] && m_hready_o[0] && m_haddr_i[0][31:28] inside {4'h3, [4'h6:4'hf]}
        |=> !m_hready_o[0] && m_hresp_o[0] ##1 m_hready_o[0] && m_hresp_o[0])
        else $error("error");
    AST_REG_IDLE: assert property (!$past(reg_re_i) |-> reg_rdata_o == '0)
        else $error("idle");
    AST_PRIO_BITS: assert property (reg_re_i && reg_addr_i == OFF_PRIO |=> (reg_rdata_o & 32'hffff_eeee) == '0)
        else $error("prio");
    AST_WR_CLEAR: assert property (reg_we_i && reg_addr_i == 8'h08 ##1 reg_re_i && reg_addr_i == 8'h08
        |=> reg_rdata_o[AHB_DW-1:1] == '0)
        else $error("clear");
    cover property (g0 && m_htrans_i[1][1]);
    cover property (m_hresp_o[0]);
    cover property (reg_we_i ##1 reg_re_i);
endmodule
bind axb_crossbar axb_crossbar_properties axb_crossbar_properties_inst (.*);
`default_nettype wire

// File: tb/axb_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module axb_slave_model
    import axb_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [NUM_SLV-1:0] hsel_i,
    input wire logic [NUM_SLV-1:0][AHB_AW-1:0] haddr_i,
    input wire logic [NUM_SLV-1:0][1:0] htrans_i,
    input wire logic [NUM_SLV-1:0] hready_i,
    input wire logic [NUM_SLV-1:0] stall_i,
    output logic [NUM_SLV-1:0][AHB_DW-1:0] hrdata_o,
    output logic [NUM_SLV-1:0] hreadyout_o,
    output logic [NUM_SLV-1:0] hresp_o
);
    logic [NUM_SLV-1:0][AHB_AW-1:0] addr_q;
    logic [NUM_SLV-1:0] act_q, wt_q;
    // stalled ports add one wait state
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            act_q <= '0;
            wt_q <= '0;
            addr_q <= '0;
        end else begin
            for (int p = 0; p < NUM_SLV; p++) begin
                wt_q[p] <= act_q[p] && stall_i[p] && !wt_q[p];
                if (hready_i[p]) begin
                    act_q[p] <= hsel_i[p] && htrans_i[p][1];
                    addr_q[p] <= haddr_i[p];
                end
            end
        end
    end
    // idle data shows the inverted last address
    always_comb begin
        for (int p = 0; p < NUM_SLV; p++) begin
            hreadyout_o[p] = !(act_q[p] && stall_i[p] && !wt_q[p]);
            hresp_o[p] = HRESP_OKAY;
            hrdata_o[p] = act_q[p] ? addr_q[p] ^ 32'h5a5a_0000 : ~addr_q[p];
        end
    end
endmodule
`default_nettype wire

// File: tb/test_ahb_crossbar_4x10_prio_perf.sv
`timescale 1ns/1ps
`default_nettype none
module test_ahb_crossbar_4x10_prio_perf;
    import axb_pkg::*;
    logic clk_i = 0, rst_n_i = 0, we = 0, re = 0;
    logic [NUM_MST-1:0][AHB_AW-1:0] ha = '0;
    logic [NUM_MST-1:0][1:0] ht = '0;
    logic [NUM_SLV-1:0] stall = '0;
    logic [REG_AW-1:0] ra = '0;
    logic [AHB_DW-1:0] rw = '0;
    wire logic [NUM_MST-1:0][AHB_DW-1:0] hr;
    wire logic [NUM_MST-1:0] hy, hs;
    wire logic [NUM_SLV-1:0] sel, sro, srs, sy;
    wire logic [NUM_SLV-1:0][AHB_AW-1:0] sa;
    wire logic [NUM_SLV-1:0][1:0] st;
    wire logic [NUM_SLV-1:0][MST_W-1:0] sm;
    wire logic [NUM_SLV-1:0][AHB_DW-1:0] sd;
    wire logic [AHB_DW-1:0] rd;
    int fails = 0, cmp_count = 0;
    always #4 clk_i = ~clk_i;
    axb_crossbar axb_crossbar_inst (.clk_i, .rst_n_i, .m_haddr_i(ha), .m_htrans_i(ht), .m_hwrite_i('0),
        .m_hsize_i('0), .m_hburst_i('0), .m_hprot_i('0), .m_hwdata_i('0), .m_hrdata_o(hr), .m_hready_o(hy),
        .m_hresp_o(hs), .s_hsel_o(sel), .s_haddr_o(sa), .s_htrans_o(st), .s_hwrite_o(), .s_hsize_o(),
        .s_hburst_o(), .s_hprot_o(), .s_hmaster_o(sm), .s_hwdata_o(), .s_hready_o(sy), .s_hrdata_i(sd),
        .s_hreadyout_i(sro), .s_hresp_i(srs), .reg_addr_i(ra), .reg_wdata_i(rw), .reg_we_i(we),
        .reg_re_i(re), .reg_rdata_o(rd));
    axb_slave_model axb_slave_model_inst (.clk_i, .rst_n_i, .hsel_i(sel), .haddr_i(sa), .htrans_i(st),
        .hready_i(sy), .stall_i(stall), .hrdata_o(sd), .hreadyout_o(sro), .hresp_o(srs));
    task automatic chk(input logic [AHB_DW-1:0] seen, input logic [AHB_DW-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (fails == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    function automatic logic [AHB_AW-1:0] adr(input int p);
        case (p)
            0: return 32'h0000_0040;
            1: return 32'h1000_0040;
            8: return 32'h5000_0040;
            9: return 32'h4000_0040;
            default: return 32'h2000_0040 + (32'(p - 2) << 15);
        endcase
    endfunction
    task automatic wr(input logic [REG_AW-1:0] a, input logic [AHB_DW-1:0] d);
        ra <= a;
        rw <= d;
        we <= 1;
        @(posedge clk_i);
        we <= 0;
    endtask
    task automatic rc(input logic [REG_AW-1:0] a, input logic [AHB_DW-1:0] e);
        ra <= a;
        re <= 1;
        @(posedge clk_i);
        re <= 0;
        @(negedge clk_i);
        chk(rd, e);
        @(posedge clk_i);
    endtask
    task automatic ar(input int m, input logic [AHB_AW-1:0] a, input logic r);
        int n = 0;
        ha[m] <= a;
        ht[m] <= 2'h2;
        @(posedge clk_i);
        ht[m] <= 2'h0;
        @(negedge clk_i);
        while (hy[m] !== 1'b1 && n < 20) begin
            @(negedge clk_i);
            n++;
        end
        chk({hy[m], hs[m]}, {1'b1, r});
        if (!r) chk(hr[m], a ^ 32'h5a5a_0000);
        @(posedge clk_i);
    endtask
    task automatic t_regs();
        rc(OFF_PRIO, '0);
        rc(8'h0c, 32'h1f);
        wr(OFF_PRIO, 32'hffff_ffff);
        rc(OFF_PRIO, 32'h1111);
        rc(8'hfc, '0);
        wr(OFF_PRIO, '0);
        wr(8'h08, 32'h1234_5678);
        rc(8'h08, '0);
    endtask
    task automatic t_route();
        for (int m = 0; m < 4; m++) begin
            stall <= (m == 3) ? '1 : '0;
            for (int p = 0; p < 10; p++) ar(m, adr(p), 1'b0);
            ar(m, 32'h3000_0000, 1'b1);
            ar(m, 32'h2003_0000, 1'b1);
        end
        stall <= '0;
    endtask
    task automatic t_conc();
        for (int m = 0; m < 4; m++) begin
            ha[m] <= adr(m + 2);
            ht[m] <= 2'h2;
        end
        @(negedge clk_i);
        chk(sel, 10'h03c);
        @(posedge clk_i);
        ht <= '0;
        @(negedge clk_i);
        chk(hy, 4'hf);
        for (int m = 0; m < 4; m++) chk(hr[m], adr(m + 2) ^ 32'h5a5a_0000);
        @(posedge clk_i);
    endtask
    task automatic t_sel();
        for (int c = 0; c < 20; c++) begin
            wr(8'h0c, 32'(c));
            wr(8'h08, '0);
            ar(0, adr(9 - c / 2), 1'b0);
            rc(8'h08, 32'(c % 2));
        end
    endtask
    task automatic t_cont(input logic [AHB_DW-1:0] pr, input logic [5:0] ord);
        wr(OFF_PRIO, pr);
        wr(8'h08, '0);
        wr(8'h10, '0);
        for (int m = 0; m < 3; m++) begin
            ha[m] <= adr(2);
            ht[m] <= 2'h2;
        end
        for (int i = 0; i < 3; i++) begin
            @(negedge clk_i);
            chk({sel[2], sm[2]}, {1'b1, ord[i*2 +: 2]});
            @(posedge clk_i);
            ht <= '0;
        end
        repeat (4) @(posedge clk_i);
        rc(8'h08, 32'h2);
        rc(8'h10, 32'h3);
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1;
        @(posedge clk_i);
        t_regs();
        t_route();
        t_conc();
        t_sel();
        wr(8'h0c, 32'he);
        wr(8'h14, 32'hf);
        t_cont(32'h0, 6'b00_10_01);
        t_cont(32'h100, 6'b00_01_10);
        t_cont(32'h0, 6'b00_10_01);
        conclude();
    end
    initial begin
        #100000;
        fails++;
        conclude();
    end
endmodule
`default_nettype wire
